/* common/eaml_pkg.sv */
/*
 eaml_pkg: constants for the effective address mode logic.
 assumes a 32-bit apb register bus and big-endian bit 1 = msb.
*/
package eaml_pkg;
    // addressing modes (virtual, general register, relative, sectored)
    typedef enum logic [1:0] {
        EAML_MODE_V = 2'b00,
        EAML_MODE_I = 2'b01,
        EAML_MODE_R = 2'b10,
        EAML_MODE_S = 2'b11
    } eaml_mode_e;
    // where ring, byte flag and segment come from
    typedef enum logic [1:0] {
        EAML_SRC_BASE = 2'b00,
        EAML_SRC_IP   = 2'b01,
        EAML_SRC_GRR  = 2'b10,
        EAML_SRC_RSV  = 2'b11
    } eaml_src_e;
    // register byte offsets
    localparam logic [7:0] EAML_OFS_MODE  = 8'h00;
    localparam logic [7:0] EAML_OFS_INSTR = 8'h04;
    localparam logic [7:0] EAML_OFS_PC    = 8'h08;
    localparam logic [7:0] EAML_OFS_SB    = 8'h0C;
    localparam logic [7:0] EAML_OFS_LB    = 8'h10;
    localparam logic [7:0] EAML_OFS_XB    = 8'h14;
    localparam logic [7:0] EAML_OFS_IP    = 8'h18;
    localparam logic [7:0] EAML_OFS_HWORD = 8'h1C;
    localparam logic [7:0] EAML_OFS_GR0   = 8'h20;
    localparam logic [7:0] EAML_OFS_GR7   = 8'h3C;
    localparam logic [7:0] EAML_OFS_EA    = 8'h40;
    localparam logic [7:0] EAML_OFS_STAT  = 8'h44;
    localparam logic [7:0] EAML_OFS_CHAR  = 8'h48;
    // general register file
    localparam int         EAML_NUM_GR    = 8;
    localparam logic [2:0] EAML_GR_NOIDX  = 3'h0;
    // pointer layout, bit n of the manual is index 32-n
    localparam int EAML_PTR_FAULT = 31;
    localparam int EAML_PTR_RING_HI = 30;
    localparam int EAML_PTR_RING_LO = 29;
    localparam int EAML_PTR_BLANE = 28;
    localparam int EAML_PTR_SEG_HI = 27;
    localparam int EAML_PTR_SEG_LO = 16;
    localparam int EAML_PTR_OFS_HI = 15;
    // instruction register fields
    localparam int EAML_IN_BR_LO  = 16;
    localparam int EAML_IN_SR_LO  = 18;
    localparam int EAML_IN_SFLAG  = 21;
    // sector geometry and relative window
    localparam logic [15:0] EAML_SECTOR_MASK = 16'h01FF;
    localparam logic signed [15:0] EAML_REL_MIN = -16'sh00F0;
    localparam logic signed [15:0] EAML_REL_MAX = 16'sh00FF;
    localparam logic signed [15:0] EAML_SPC_HI  = -16'sh00F1;
    localparam logic signed [15:0] EAML_SPC_LO  = -16'sh0100;
    // reset values
    localparam logic [31:0] EAML_RST_WORD = 32'h0000_0000;
endpackage : eaml_pkg

/* src/eaml_core.sv */
/*
 eaml_core: effective address formation for the general register,
 relative and sectored addressing modes, with character pointer
 byte selection, behind an apb register slave.
 assumes a zero-wait apb master on pclk and that the decoder loads
 the instruction, program counter, bases and general registers.
*/
`timescale 1ns/10ps
`default_nettype none
module eaml_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      ea_ptr,
    output logic             ea_special,
    output logic             ea_is_reg,
    output logic [7:0]       ea_char
);
    // software-written state
    logic [31:0] mode_reg;                    // mode, long form, source
    logic [31:0] mode_next;
    logic [31:0] instr_reg;                   // disp, base sel, source reg
    logic [31:0] instr_next;
    logic [31:0] pc_reg;                      // program counter pointer
    logic [31:0] pc_next;
    logic [31:0] sb_reg;                      // stack base
    logic [31:0] sb_next;
    logic [31:0] lb_reg;                      // link base
    logic [31:0] lb_next;
    logic [31:0] xb_reg;                      // auxiliary base
    logic [31:0] xb_next;
    logic [31:0] ip_reg;                      // indirect pointer
    logic [31:0] ip_next;
    logic [15:0] hword_reg;                   // fetched halfword
    logic [15:0] hword_next;
    localparam int EAML_GR_CNT = eaml_pkg::EAML_NUM_GR;
    logic [31:0] gr_reg [EAML_GR_CNT];        // general registers
    logic [31:0] gr_next [EAML_GR_CNT];
    // result state
    logic [31:0] ea_reg;                      // formed pointer
    logic [31:0] ea_next;
    logic [5:0]  stat_reg;                    // result flags
    logic [5:0]  stat_next;
    logic [7:0]  char_reg;                    // selected character
    logic [7:0]  char_next;
    logic [31:0] rdata_reg;                   // read data for the bus
    logic [31:0] rdata_next;

    // decoded control fields
    eaml_pkg::eaml_mode_e mode;
    eaml_pkg::eaml_src_e  src;
    logic        long_form;
    logic [15:0] disp;
    logic [1:0]  br_sel;
    logic [2:0]  sr_sel;
    logic        sflag;
    logic [31:0] sr_word;                     // selected source register
    logic [15:0] idx;                         // index contribution
    logic [31:0] base_word;                   // chosen base register
    logic        grr_err;                     // grr asked in v mode, or reserved source in v or long i mode
    logic        rng_err;                     // relative outside window
    logic        special;                     // special addressing band
    logic        is_reg;                      // register file reference
    logic signed [15:0] rel;                  // signed displacement
    logic        wr_en;                       // bus write strobe
    logic        addr_ok;                     // address is mapped
    logic [5:0]  widx;                        // word index of paddr

    assign mode      = eaml_pkg::eaml_mode_e'(mode_reg[1:0]);
    assign long_form = mode_reg[2];
    assign src       = eaml_pkg::eaml_src_e'(mode_reg[4:3]);
    assign disp      = instr_reg[eaml_pkg::EAML_PTR_OFS_HI:0];
    assign br_sel    = instr_reg[eaml_pkg::EAML_IN_BR_LO +: 2];
    assign sr_sel    = instr_reg[eaml_pkg::EAML_IN_SR_LO +: 3];
    assign sflag     = instr_reg[eaml_pkg::EAML_IN_SFLAG];
    assign rel       = $signed(disp);
    assign sr_word   = gr_reg[sr_sel];
    assign widx      = paddr[7:2];

    // every transfer completes in its first access cycle
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    // unmapped or misaligned addresses answer with an error
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= eaml_pkg::EAML_OFS_CHAR);
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = rdata_reg;

    // results are held in flops so the memory path sees stable data
    assign ea_ptr     = ea_reg;
    assign ea_special = stat_reg[0];
    assign ea_is_reg  = stat_reg[2];
    assign ea_char    = char_reg;

    // register file next values from bus writes
    always_comb begin
        mode_next  = mode_reg;
        instr_next = instr_reg;
        pc_next    = pc_reg;
        sb_next    = sb_reg;
        lb_next    = lb_reg;
        xb_next    = xb_reg;
        ip_next    = ip_reg;
        hword_next = hword_reg;
        for (int i = 0; i < EAML_GR_CNT; i++) begin
            gr_next[i] = gr_reg[i];
        end
        if (wr_en && addr_ok) begin
            unique case (paddr)
                eaml_pkg::EAML_OFS_MODE:  mode_next  = pwdata;
                eaml_pkg::EAML_OFS_INSTR: instr_next = pwdata;
                eaml_pkg::EAML_OFS_PC:    pc_next    = pwdata;
                eaml_pkg::EAML_OFS_SB:    sb_next    = pwdata;
                eaml_pkg::EAML_OFS_LB:    lb_next    = pwdata;
                eaml_pkg::EAML_OFS_XB:    xb_next    = pwdata;
                eaml_pkg::EAML_OFS_IP:    ip_next    = pwdata;
                eaml_pkg::EAML_OFS_HWORD: hword_next = pwdata[15:0];
                default: begin
                    // general registers sit in a contiguous block
                    if (paddr >= eaml_pkg::EAML_OFS_GR0 &&
                        paddr <= eaml_pkg::EAML_OFS_GR7) begin
                        gr_next[widx[2:0]] = pwdata;
                    end
                    // result registers are read only, writes ignored
                end
            endcase
        end
    end

    always_comb begin
        unique case (br_sel)
            2'b00: begin
                // procedure base: pc segment, offset zero
                base_word = {pc_reg[31:16], 16'h0000};
            end
            2'b01: base_word = sb_reg;
            2'b10: base_word = lb_reg;
            2'b11: base_word = xb_reg;
        endcase
    end

    // index register from the source register field
    always_comb begin
        idx = 16'h0000;
        if (mode == eaml_pkg::EAML_MODE_I && long_form) begin
            if (sr_sel != eaml_pkg::EAML_GR_NOIDX) begin
                // the offset part is the low half
                idx = sr_word[eaml_pkg::EAML_PTR_OFS_HI:0];
            end
        end
    end

    // effective address formation, all modes
    always_comb begin
        ea_next = eaml_pkg::EAML_RST_WORD;
        grr_err = 1'b0;
        rng_err = 1'b0;
        special = 1'b0;
        is_reg  = 1'b0;
        unique case (mode)
            eaml_pkg::EAML_MODE_V,
            eaml_pkg::EAML_MODE_I: begin
                if (mode == eaml_pkg::EAML_MODE_I && !long_form) begin
                    // short form names one of eight registers
                    is_reg  = 1'b1;
                    ea_next = {29'h0000_0000, sr_sel};
                end else if (src == eaml_pkg::EAML_SRC_GRR &&
                             mode == eaml_pkg::EAML_MODE_I) begin
                    // segment from bits 5-16, offset disp plus low half
                    // ring, byte flag and segment from the register
                    ea_next[31:16] = sr_word[31:16];
                    // offset wraps inside the 128 kbyte segment
                    ea_next[15:0]  = sr_word[15:0] + disp;
                end else if (src == eaml_pkg::EAML_SRC_IP) begin
                    // indirect pointer supplies ring, flag, segment
                    ea_next[31:16] = ip_reg[31:16];
                    ea_next[15:0]  = ip_reg[15:0] + idx;
                end else begin
                    // long form: base plus displacement plus index
                    // grr outside general-register mode falls back
                    grr_err = (src == eaml_pkg::EAML_SRC_GRR) ||
                              (src == eaml_pkg::EAML_SRC_RSV);
                    ea_next[31:16] = base_word[31:16];
                    // base source forces the byte flag to zero
                    ea_next[eaml_pkg::EAML_PTR_BLANE] = 1'b0;
                    ea_next[15:0] = base_word[15:0] + disp + idx;
                end
            end
            eaml_pkg::EAML_MODE_R: begin
                ea_next[31:16] = pc_reg[31:16];
                if (!sflag) begin
                    // clear flag confines to sector zero
                    ea_next[15:0] = disp & eaml_pkg::EAML_SECTOR_MASK;
                end else if (rel >= eaml_pkg::EAML_REL_MIN &&
                             rel <= eaml_pkg::EAML_REL_MAX) begin
                    ea_next[15:0] = pc_reg[15:0] + disp;
                end else if (rel <= eaml_pkg::EAML_SPC_HI &&
                             rel >= eaml_pkg::EAML_SPC_LO) begin
                    special       = 1'b1;
                    ea_next[15:0] = disp;
                end else begin
                    // outside both bands: flagged, address still formed
                    rng_err       = 1'b1;
                    ea_next[15:0] = pc_reg[15:0] + disp;
                end
            end
            eaml_pkg::EAML_MODE_S: begin
                ea_next[31:16] = pc_reg[31:16];
                if (!sflag) begin
                    ea_next[15:0] = disp & eaml_pkg::EAML_SECTOR_MASK;
                end else begin
                    // sector base is n times 512
                    ea_next[15:0] = (pc_reg[15:0] & ~eaml_pkg::EAML_SECTOR_MASK) |
                                    (disp & eaml_pkg::EAML_SECTOR_MASK);
                end
            end
        endcase
    end

    // status and character selection from the formed pointer
    always_comb begin
        stat_next    = 6'h00;
        stat_next[0] = special;
        // null character pointer test on bits 4 to 32
        stat_next[1] = (ea_next[eaml_pkg::EAML_PTR_BLANE:0] == 29'h0000_0000);
        stat_next[2] = is_reg;
        stat_next[3] = grr_err;
        // bit 4 of the pointer is the byte flag
        stat_next[4] = ea_next[eaml_pkg::EAML_PTR_BLANE];
        stat_next[5] = rng_err;
        // flag 0 picks bits 1-8, flag 1 bits 9-16
        if (ea_next[eaml_pkg::EAML_PTR_BLANE]) begin
            char_next = hword_reg[7:0];
        end else begin
            char_next = hword_reg[15:8];
        end
    end

    // read data is captured in the setup cycle, so it is flop driven
    always_comb begin
        rdata_next = rdata_reg;
        if (psel && !penable) begin
            rdata_next = 32'h0000_0000;
            unique case (paddr)
                eaml_pkg::EAML_OFS_MODE:  rdata_next = {27'h000_0000, mode_reg[4:0]};
                eaml_pkg::EAML_OFS_INSTR: rdata_next = {10'h000, instr_reg[21:0]};
                eaml_pkg::EAML_OFS_PC:    rdata_next = pc_reg;
                eaml_pkg::EAML_OFS_SB:    rdata_next = sb_reg;
                eaml_pkg::EAML_OFS_LB:    rdata_next = lb_reg;
                eaml_pkg::EAML_OFS_XB:    rdata_next = xb_reg;
                eaml_pkg::EAML_OFS_IP:    rdata_next = ip_reg;
                eaml_pkg::EAML_OFS_HWORD: rdata_next = {16'h0000, hword_reg};
                eaml_pkg::EAML_OFS_EA:    rdata_next = ea_reg;
                eaml_pkg::EAML_OFS_STAT:  rdata_next = {26'h000_0000, stat_reg};
                eaml_pkg::EAML_OFS_CHAR:  rdata_next = {24'h00_0000, char_reg};
                default: begin
                    if (paddr >= eaml_pkg::EAML_OFS_GR0 &&
                        paddr <= eaml_pkg::EAML_OFS_GR7 && addr_ok) begin
                        rdata_next = gr_reg[widx[2:0]];
                    end
                end
            endcase
        end
    end

    // all state registers; reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg  <= eaml_pkg::EAML_RST_WORD;
            instr_reg <= eaml_pkg::EAML_RST_WORD;
            pc_reg    <= eaml_pkg::EAML_RST_WORD;
            sb_reg    <= eaml_pkg::EAML_RST_WORD;
            lb_reg    <= eaml_pkg::EAML_RST_WORD;
            xb_reg    <= eaml_pkg::EAML_RST_WORD;
            ip_reg    <= eaml_pkg::EAML_RST_WORD;
            hword_reg <= 16'h0000;
            for (int i = 0; i < EAML_GR_CNT; i++) begin
                gr_reg[i] <= eaml_pkg::EAML_RST_WORD;
            end
            ea_reg    <= eaml_pkg::EAML_RST_WORD;
            stat_reg  <= 6'h00;
            char_reg  <= 8'h00;
            rdata_reg <= eaml_pkg::EAML_RST_WORD;
        end else begin
            mode_reg  <= mode_next;
            instr_reg <= instr_next;
            pc_reg    <= pc_next;
            sb_reg    <= sb_next;
            lb_reg    <= lb_next;
            xb_reg    <= xb_next;
            ip_reg    <= ip_next;
            hword_reg <= hword_next;
            for (int i = 0; i < EAML_GR_CNT; i++) begin
                gr_reg[i] <= gr_next[i];
            end
            ea_reg    <= ea_next;
            stat_reg  <= stat_next;
            char_reg  <= char_next;
            rdata_reg <= rdata_next;
        end
    end
endmodule : eaml_core
`default_nettype wire

/* verif/eaml_core_checker.sv */
/*
 eaml_core_checker: port-level assertions for the effective address block.
 assumes one clock domain, async active-low reset and a zero-wait apb slave.
*/
`timescale 1ns/10ps
`default_nettype none
module eaml_core_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] ea_ptr,
    input wire logic        ea_special,
    input wire logic        ea_is_reg,
    input wire logic [7:0]  ea_char
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic        acc  = psel && penable;          // access phase
    wire logic        wr_w = psel && penable && pwrite; // write commit
    wire logic        bad  = (paddr > 8'h48) || (paddr[1:0] != 2'b00);
    logic      [15:0] hw_reg, hw_next;                 // shadow of the halfword
    logic      [1:0]  qt_reg, qt_next;                 // cycles since last write
    // shadow next state: char check waits until the result has settled
    always_comb begin
        hw_next = hw_reg;
        qt_next = (qt_reg == 2'd3) ? qt_reg : qt_reg + 2'd1;
        if (wr_w) begin
            qt_next = 2'd0;
            if (paddr == eaml_pkg::EAML_OFS_HWORD) begin
                hw_next = pwdata[15:0];
            end
        end
    end
    // shadow registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_reg <= 16'h0000;
            qt_reg <= 2'd0;
        end else begin
            hw_reg <= hw_next;
            qt_reg <= qt_next;
        end
    end
    a_ready_high: assert property (pready)
        else $error("pready not high");
    a_err_bad: assert property (acc && bad |-> pslverr)
        else $error("no error on unmapped address");
    a_err_good: assert property (acc && !bad |-> !pslverr)
        else $error("error on mapped address");
    a_err_idle: assert property (!acc |-> !pslverr)
        else $error("error outside access phase");
    a_bad_read_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_ea_readback: assert property (acc && !pwrite && paddr == eaml_pkg::EAML_OFS_EA
        |-> prdata == $past(ea_ptr))
        else $error("ea read differs from port");
    a_ea_cause: assert property (!$stable(ea_ptr) |-> $past(wr_w, 2))
        else $error("ea moved without a write");
    a_ea_ro_write: assert property (wr_w && paddr == eaml_pkg::EAML_OFS_EA
        |-> ##2 $stable(ea_ptr))
        else $error("write to ea changed it");
    a_char_lane: assert property (qt_reg >= 2'd2 |->
        ea_char == (ea_ptr[28] ? hw_reg[7:0] : hw_reg[15:8]))
        else $error("wrong character lane");
endmodule : eaml_core_checker
bind eaml_core eaml_core_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ea_ptr(ea_ptr), .ea_special(ea_special),
    .ea_is_reg(ea_is_reg), .ea_char(ea_char));
`default_nettype wire

/* verif/eaml_apb_master.sv */
/*
 eaml_apb_master: decoder-side model issuing apb transfers.
 assumes callers enter xfer from a procedural thread of the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module eaml_apb_master (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata
);
    // idle bus from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end
    // one transfer; request held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // wait for the answer; only the bench watchdog ends a stuck wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : eaml_apb_master
`default_nettype wire

/* verif/effective_address_mode_logic_test.sv */
/*
 effective_address_mode_logic_test: scenario tasks for eaml_core over apb.
 assumes result outputs settle one edge after the register write.
*/
`timescale 1ns/10ps
`default_nettype none
module effective_address_mode_logic_test;
    logic        pclk, presetn;          // clock and active-low reset
    wire  logic  psel, penable, pwrite, pready, pslverr, ea_special, ea_is_reg;
    wire  logic [7:0]  paddr, ea_char;   // bus address, selected character
    wire  logic [31:0] pwdata, prdata, ea_ptr;
    int          n_errors = 0;           // mismatches seen
    int          num_checks = 0;         // comparisons made
    localparam logic [31:0] PCV = 32'h3123_0456;  // ring and flag bits set on purpose
    eaml_apb_master u_mst (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    eaml_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ea_ptr(ea_ptr), .ea_special(ea_special), .ea_is_reg(ea_is_reg),
        .ea_char(ea_char));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    function automatic logic [31:0] ins(logic sf, logic [2:0] sr, logic [1:0] br,
                                        logic [15:0] d);
        return {10'h000, sf, sr, br, d};
    endfunction : ins
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        u_mst.xfer(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        u_mst.xfer(1'b0, a, 32'h0000_0000, r, e);
    endtask : rd
    // result lands one edge after the write edge
    task automatic settle;
        @(posedge pclk);
        #1;
    endtask : settle
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // reset state, unmapped and read-only places
    task automatic t_reset_bus;
        logic [31:0] r;
        logic        e;
        chk(ea_ptr, 32'h0000_0000);
        rd(eaml_pkg::EAML_OFS_STAT, r);
        chk(r, 32'h0000_0002);
        u_mst.xfer(1'b0, 8'h4C, 32'h0000_0000, r, e);
        chk({e, r[30:0]} ^ {1'b0, 31'h0}, 32'h8000_0000);
        u_mst.xfer(1'b1, 8'h02, 32'hFFFF_FFFF, r, e);
        chk({31'h0, e}, 32'h0000_0001);
        wr(eaml_pkg::EAML_OFS_EA, 32'hFFFF_FFFF);
        rd(eaml_pkg::EAML_OFS_EA, r);
        chk(r, 32'h0000_0000);
    endtask : t_reset_bus
    // each base selector, forced byte flag
    task automatic t_bases;
        logic [31:0] b [4];
        b = '{{PCV[31:16], 16'h0000}, 32'h1055_0010, 32'h2066_0020, 32'h5077_FFF0};
        wr(eaml_pkg::EAML_OFS_PC, PCV);
        wr(eaml_pkg::EAML_OFS_SB, b[1]);
        wr(eaml_pkg::EAML_OFS_LB, b[2]);
        wr(eaml_pkg::EAML_OFS_XB, b[3]);
        wr(eaml_pkg::EAML_OFS_MODE, 32'h0000_0004);
        for (int i = 0; i < 4; i++) begin
            wr(eaml_pkg::EAML_OFS_INSTR, ins(1'b0, 3'd0, 2'(i), 16'h0020));
            settle();
            chk(ea_ptr, {b[i][31:29], 1'b0, b[i][27:16], b[i][15:0] + 16'h0020});
        end
    endtask : t_bases
    // index by source field, register 0 adds nothing
    task automatic t_imode;
        logic [31:0] r;
        for (int i = 0; i < 8; i++) begin
            wr(eaml_pkg::EAML_OFS_GR0 + 8'(4 * i), {16'h0F0F, 13'h0020, 3'(i)});
        end
        wr(eaml_pkg::EAML_OFS_MODE, 32'h0000_0005);
        for (int i = 0; i < 8; i++) begin
            wr(eaml_pkg::EAML_OFS_INSTR, ins(1'b0, 3'(i), 2'd1, 16'h0020));
            settle();
            r = (i == 0) ? 32'h0 : {16'h0, 13'h0020, 3'(i)};
            chk(ea_ptr, {16'h0055, 16'h0030 + r[15:0]});
        end
        wr(eaml_pkg::EAML_OFS_GR0 + 8'h0C, 32'h3ABC_1000);
        wr(eaml_pkg::EAML_OFS_MODE, 32'h0000_0015);
        wr(eaml_pkg::EAML_OFS_INSTR, ins(1'b0, 3'd3, 2'd1, 16'h0024));
        settle();
        chk(ea_ptr, 32'h3ABC_1024);
        wr(eaml_pkg::EAML_OFS_MODE, 32'h0000_0014);
        rd(eaml_pkg::EAML_OFS_STAT, r);
        chk({31'h0, r[3]}, 32'h0000_0001);
        wr(eaml_pkg::EAML_OFS_MODE, 32'h0000_0001);
        wr(eaml_pkg::EAML_OFS_INSTR, ins(1'b0, 3'd5, 2'd0, 16'h0000));
        settle();
        chk({28'h0, ea_is_reg, ea_ptr[2:0]}, 32'h0000_000D);
    endtask : t_imode
    // character pointer lanes and null test
    task automatic t_ptr;
        logic [31:0] r;
        wr(eaml_pkg::EAML_OFS_HWORD, 32'h0000_A55A);
        wr(eaml_pkg::EAML_OFS_MODE, 32'h0000_000C);
        wr(eaml_pkg::EAML_OFS_IP, 32'h1345_0100);
        wr(eaml_pkg::EAML_OFS_INSTR, ins(1'b0, 3'd0, 2'd0, 16'h0002));
        settle();
        chk(ea_ptr, 32'h1345_0100);
        chk({24'h0, ea_char}, 32'h0000_005A);
        wr(eaml_pkg::EAML_OFS_IP, 32'h0345_0100);
        settle();
        chk({24'h0, ea_char}, 32'h0000_00A5);
        wr(eaml_pkg::EAML_OFS_IP, 32'h8000_0000);
        wr(eaml_pkg::EAML_OFS_INSTR, ins(1'b0, 3'd0, 2'd0, 16'h0000));
        rd(eaml_pkg::EAML_OFS_STAT, r);
        chk({31'h0, r[1]}, 32'h0000_0001);
        wr(eaml_pkg::EAML_OFS_IP, 32'h8000_0001);
        rd(eaml_pkg::EAML_OFS_STAT, r);
        chk({31'h0, r[1]}, 32'h0000_0000);
    endtask : t_ptr
    task automatic t_rel;
        logic [15:0] d [4];
        logic [31:0] r;
        d = '{16'hFF10, 16'h00FF, 16'hFF0F, 16'hFF00};
        wr(eaml_pkg::EAML_OFS_PC, 32'h0012_0A40);
        wr(eaml_pkg::EAML_OFS_MODE, 32'h0000_0002);
        for (int i = 0; i < 4; i++) begin
            wr(eaml_pkg::EAML_OFS_INSTR, ins(1'b1, 3'd0, 2'd0, d[i]));
            settle();
            chk({31'h0, ea_special}, (i >= 2) ? 32'h1 : 32'h0);
            if (i < 2) chk({16'h0, ea_ptr[15:0]}, {16'h0, 16'h0A40 + d[i]});
        end
        wr(eaml_pkg::EAML_OFS_INSTR, ins(1'b1, 3'd0, 2'd0, 16'h0100));
        rd(eaml_pkg::EAML_OFS_STAT, r);
        chk({31'h0, r[5]}, 32'h0000_0001);
        for (int m = 2; m < 4; m++) begin
            wr(eaml_pkg::EAML_OFS_MODE, 32'(m));
            wr(eaml_pkg::EAML_OFS_INSTR, ins(1'b0, 3'd0, 2'd0, 16'h0345));
            settle();
            chk({4'h0, ea_ptr[27:0]}, 32'h0012_0145);
        end
        wr(eaml_pkg::EAML_OFS_INSTR, ins(1'b1, 3'd0, 2'd0, 16'h0123));
        settle();
        chk({4'h0, ea_ptr[27:0]}, 32'h0012_0B23);
    endtask : t_rel
    // main sequence
    initial begin
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        t_reset_bus();
        t_bases();
        t_imode();
        t_ptr();
        t_rel();
        report_and_stop();
    end
    // watchdog, about twenty times the expected run
    initial begin
        #20000;
        n_errors++;
        report_and_stop();
    end
endmodule : effective_address_mode_logic_test
`default_nettype wire
